/* File: verilog/csc_top.sv */
// Cam signal conditioning: input sync, cam delay, cam stretch, index
// gating, cam health, engine state, fault flags and TDC angle registers.
// Assumes one 40 MHz clock and a tracker core that supplies speed,
// feature pulses, sync state and fault events.
//
// Notes on behaviour
// - Auto-clear on: fault flags cleared while engine state is cranking.
// - Delay counting starts at rising edge of selected cam.
// - Delayed output rises at crank fall after programmed crank rises.
// - Delayed output falls at next crank rise: half a tooth wide.
// - Delay disabled: selected cam passes through unchanged.
// - Delay input is phase input a or b as selected.
// - Delay output always feeds the stretch stage.
// - Stretch holds high for programmed teeth from input rise.
// - Stretch width depends only on tooth count, may be shorter.
// - Stretch disabled: delay output passes through unchanged.
// - Stretch output feeds index gating and the tracker phase input.
// - Cam health reported at features, gap patterns, only when synced.
// - Health is normal, error, always high or always low.
// - Health error never forces loss of sync.
// - Gap patterns: select picks cam driving synchronization.
// - Encoder patterns: select picks cam gating the index.
// - Gated mode: index ANDed with stretch output of selected cam.
// - Pass mode: index forwarded regardless of cam.
// - Live level indicators are coarse reference samples.
// - Zero-to-first-TDC angle is signed crank degrees.
// - Cylinder TDC angles relative to first TDC, mapped separately.
// - Any fault flag forces sync loss until cleared.
// - Cranking when speed above stall and below run limit.
// - Manual fault clear clears flags and self-resets.
`timescale 1ns/1ps

module csc_top
    import csc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        crank_i,
    input  wire logic        phase_input_a_i,
    input  wire logic        phase_input_b_i,
    input  wire logic        encoder_index_pulse_i,
    input  wire logic [15:0] engine_speed_i,
    input  wire logic        feature_i,
    input  wire logic        synced_i,
    input  wire logic [3:0]  fault_set_i,
    output logic             phase_out_o,
    output logic             index_o,
    output logic      [3:0]  fault_flags_o,
    output logic             sync_block_o,
    output logic      [1:0]  engine_run_state_o,
    output logic      [1:0]  cam_phase_health_o,
    output logic             health_valid_o
);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Configuration registers
    csc_ctl_t    ctl;
    logic [7:0]  cam_delay_teeth;
    logic [7:0]  cam_stretch_teeth;
    logic [15:0] stall_rpm_limit;
    logic [15:0] run_rpm_limit;
    logic [15:0] zero_to_first_tdc_angle;
    logic [23:0] injector_tdc_map;
    logic [11:0] port_injector_tdc_map;
    logic [15:0] cylinder_tdc_angle [CSC_CYL_N];

    // Pipeline state
    logic [3:0]  s1, s2, s3;
    logic [3:0]  rise, fall;
    csc_dly_t    dly_st, next_dly_st;
    logic [7:0]  dly_cnt, next_dly_cnt;
    logic        dly_q, next_dly_q;
    logic        delay_prev;
    logic        str_q, next_str_q;
    logic [7:0]  str_cnt, next_str_cnt;
    logic [3:0]  hist;
    logic [2:0]  hist_n;
    logic [3:0]  next_flags;

    // Input synchronisers
    // Order of bits: crank, input a, input b, index. Stage one feeds
    // only stage two so no edge logic sees a metastable level.
    wire [3:0] raw_in = {encoder_index_pulse_i, phase_input_b_i,
                         phase_input_a_i, crank_i};
    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge clock_i) begin
            if (rst_i) begin
                s1[g] <= 1'b0;
                s2[g] <= 1'b0;
                s3[g] <= 1'b0;
            end else begin
                s1[g] <= raw_in[g];
                s2[g] <= s1[g];
                s3[g] <= s2[g];
            end
        end
        assign rise[g] = s2[g] & ~s3[g];
        assign fall[g] = ~s2[g] & s3[g];
    end

    // Same select drives the tracker phase input
    wire crank_rise = rise[0];
    wire crank_fall = fall[0];
    wire cam_sel    = ctl.phase_input_sel ? s2[2] : s2[1];
    wire cam_rise   = ctl.phase_input_sel ? rise[2] : rise[1];
    wire dly_hit    = (dly_cnt == cam_delay_teeth);

    // Delay state machine; a fresh cam rise restarts the count
    always_comb begin
        next_dly_st  = dly_st;
        next_dly_cnt = dly_cnt;
        next_dly_q   = dly_q;
        unique case (dly_st)
            CSC_D_IDLE: begin
                if (cam_rise) begin
                    next_dly_st  = CSC_D_COUNT;
                    next_dly_cnt = 8'h00;
                end
            end
            CSC_D_COUNT: begin
                if (cam_rise) begin
                    next_dly_cnt = 8'h00;
                end else if (dly_hit && crank_fall) begin
                    next_dly_st = CSC_D_PULSE;
                    next_dly_q  = 1'b1;
                end else if (!dly_hit && crank_rise) begin
                    next_dly_cnt = dly_cnt + 8'h01;
                end
            end
            CSC_D_PULSE: begin
                if (cam_rise) begin
                    next_dly_st  = CSC_D_COUNT;
                    next_dly_cnt = 8'h00;
                    next_dly_q   = 1'b0;
                end else if (crank_rise) begin
                    next_dly_st = CSC_D_IDLE;
                    next_dly_q  = 1'b0;
                end
            end
            default: begin
                next_dly_st = CSC_D_IDLE;
                next_dly_q  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dly_st  <= CSC_D_IDLE;
            dly_cnt <= 8'h00;
            dly_q   <= 1'b0;
        end else begin
            dly_st  <= next_dly_st;
            dly_cnt <= next_dly_cnt;
            dly_q   <= next_dly_q;
        end
    end

    wire delay_out  = ctl.cam_delay_en ? dly_q : cam_sel;
    wire delay_rise = delay_out & ~delay_prev;

    // Width set by count alone; input fall is ignored
    always_comb begin
        next_str_q   = str_q;
        next_str_cnt = str_cnt;
        if (delay_rise && cam_stretch_teeth != 8'h00) begin
            next_str_q   = 1'b1;
            next_str_cnt = 8'h00;
        end else if (str_q && crank_rise) begin
            next_str_cnt = str_cnt + 8'h01;
            if (next_str_cnt == cam_stretch_teeth) begin
                next_str_q = 1'b0;
            end
        end
    end

    wire stretch_out = ctl.cam_stretch_en ? str_q : delay_out;
    wire index_sel   = ctl.index_gate_mode
                     ? (s2[3] & stretch_out) : s2[3];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            delay_prev <= 1'b0;
            str_q      <= 1'b0;
            str_cnt    <= 8'h00;
        end else begin
            delay_prev <= delay_out;
            str_q      <= next_str_q;
            str_cnt    <= next_str_cnt;
        end
    end

    // Stretched cam to tracker and to index gating
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            phase_out_o <= 1'b0;
            index_o     <= 1'b0;
        end else begin
            phase_out_o <= stretch_out;
            index_o     <= index_sel;
        end
    end

    // Engine state from speed
    // Equal to the stall limit counts as stalled, equal to the run limit as running
    wire csc_run_t run_next =
        (engine_speed_i <= stall_rpm_limit) ? CSC_STALLED :
        (engine_speed_i <  run_rpm_limit)   ? CSC_CRANKING : CSC_RUNNING;

    // Manual clear is a write pulse, nothing to reset later
    wire ctrl_wr  = wr_i && addr_i == CSC_CTRL_OFS;
    wire man_clr  = ctrl_wr && wdata_i[CSC_CLR_BIT];
    wire auto_clr = ctl.auto_clear &&
                    engine_run_state_o == CSC_CRANKING;
    // A new fault in the clearing cycle survives: set beats clear
    assign next_flags = (fault_flags_o & {4{~(man_clr | auto_clr)}})
                      | fault_set_i;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fault_flags_o      <= 4'h0;
            sync_block_o       <= 1'b0;
            engine_run_state_o <= CSC_STALLED;
        end else begin
            fault_flags_o      <= next_flags;
            sync_block_o       <= |next_flags;
            engine_run_state_o <= run_next;
        end
    end

    // Sample cam at each feature, gap patterns only
    // Health has no path to the sync block
    wire csc_health_t health_next =
        (hist == 4'hf)                   ? CSC_H_HIGH   :
        (hist == 4'h0)                   ? CSC_H_LOW    :
        (hist == 4'ha || hist == 4'h5)   ? CSC_H_NORMAL : CSC_H_ERROR;
    wire gap_synced = synced_i && !ctl.encoder_pat;

    always_ff @(posedge clock_i) begin
        if (rst_i || !gap_synced) begin
            hist               <= 4'h0;
            hist_n             <= 3'h0;
            cam_phase_health_o <= CSC_H_NORMAL;
            health_valid_o     <= 1'b0;
        end else begin
            if (feature_i) begin
                hist <= {hist[2:0], phase_out_o};
                if (hist_n != 3'h4) begin
                    hist_n <= hist_n + 3'h1;
                end
            end
            cam_phase_health_o <= health_next;
            health_valid_o     <= (hist_n == 3'h4);
        end
    end

    // Register writes; cylinder slot picked by address bits 4..2
    wire cyl_wr = wr_i && addr_i[7:5] == CSC_CYL_OFS[7:5]
                       && addr_i[1:0] == 2'b00;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctl                     <= CSC_CTRL_RST;
            cam_delay_teeth         <= CSC_TEETH_RST;
            cam_stretch_teeth       <= CSC_TEETH_RST;
            stall_rpm_limit         <= CSC_STALL_RST;
            run_rpm_limit           <= CSC_RUN_RST;
            zero_to_first_tdc_angle <= CSC_ANGLE_RST;
            injector_tdc_map        <= 24'h000000;
            port_injector_tdc_map   <= 12'h000;
        end else if (wr_i) begin
            unique case (addr_i)
                CSC_CTRL_OFS:    ctl <= wdata_i[CSC_CTRL_W-1:0];
                CSC_DELAY_OFS:   cam_delay_teeth <= wdata_i[7:0];
                CSC_STRETCH_OFS: cam_stretch_teeth <= wdata_i[7:0];
                CSC_STALL_OFS:   stall_rpm_limit <= wdata_i[15:0];
                CSC_RUN_OFS:     run_rpm_limit <= wdata_i[15:0];
                CSC_ZTDC_OFS: zero_to_first_tdc_angle <= wdata_i[15:0];
                CSC_INJMAP_OFS:  injector_tdc_map <= wdata_i[23:0];
                CSC_PFIMAP_OFS:  port_injector_tdc_map <= wdata_i[11:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < CSC_CYL_N; i++) begin
                cylinder_tdc_angle[i] <= CSC_ANGLE_RST;
            end
        end else if (cyl_wr) begin
            cylinder_tdc_angle[addr_i[4:2]] <= wdata_i[15:0];
        end
    end

    // Cylinder slot read decode, aligned words only
    wire cyl_rd = addr_i[7:5] == CSC_CYL_OFS[7:5] && addr_i[1:0] == 2'b00;

    wire [31:0] status_word = {19'h00000, s2, health_valid_o,
                               cam_phase_health_o, engine_run_state_o,
                               fault_flags_o};
    wire [31:0] rd_mux =
        (addr_i == CSC_CTRL_OFS)    ? {26'h0, ctl}                  :
        (addr_i == CSC_DELAY_OFS)   ? {24'h0, cam_delay_teeth}      :
        (addr_i == CSC_STRETCH_OFS) ? {24'h0, cam_stretch_teeth}    :
        (addr_i == CSC_STALL_OFS)   ? {16'h0, stall_rpm_limit}      :
        (addr_i == CSC_RUN_OFS)     ? {16'h0, run_rpm_limit}        :
        (addr_i == CSC_STATUS_OFS)  ? status_word                   :
        (addr_i == CSC_ZTDC_OFS)    ? {16'h0, zero_to_first_tdc_angle} :
        (addr_i == CSC_INJMAP_OFS)  ? {8'h0, injector_tdc_map}      :
        (addr_i == CSC_PFIMAP_OFS)  ? {20'h0, port_injector_tdc_map} :
        cyl_rd ? {16'h0, cylinder_tdc_angle[addr_i[4:2]]} : 32'h0;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
        end
    end

    // Checks on the conditioning chain
    auto_clear_a: assert property (
        (ctl.auto_clear && engine_run_state_o == CSC_CRANKING
         && fault_set_i == 4'h0) |=> fault_flags_o == 4'h0)
        else $error("flags not cleared while cranking");
    delay_start_a: assert property (
        cam_rise |=> dly_st == CSC_D_COUNT && dly_cnt == 8'h00)
        else $error("delay count did not start at cam rise");
    delay_high_a: assert property (
        (dly_st == CSC_D_COUNT && dly_hit && crank_fall && !cam_rise)
        |=> dly_q ##0 dly_st == CSC_D_PULSE)
        else $error("delayed cam did not rise at crank fall");
    delay_low_a: assert property (
        (dly_st == CSC_D_PULSE && crank_rise) |=> !dly_q)
        else $error("delayed cam did not fall at crank rise");
    stretch_start_a: assert property (
        (delay_rise && cam_stretch_teeth != 8'h00) |=> str_q)
        else $error("stretch did not start at input rise");
    stretch_pass_a: assert property (
        !ctl.cam_stretch_en |=> phase_out_o == $past(delay_out))
        else $error("stretch bypass altered the signal");
    index_gate_a: assert property (
        (ctl.index_gate_mode && !stretch_out) |=> !index_o)
        else $error("index passed while cam low");
    index_pass_a: assert property (
        !ctl.index_gate_mode |=> index_o == $past(s2[3]))
        else $error("index not forwarded in pass mode");
    sync_block_a: assert property (
        sync_block_o == (fault_flags_o != 4'h0))
        else $error("sync block disagrees with flags");
    manual_clear_a: assert property (
        (man_clr && fault_set_i == 4'h0) |=> fault_flags_o == 4'h0)
        else $error("manual clear left flags set");
    health_gate_a: assert property (
        !gap_synced |=> !health_valid_o)
        else $error("health reported outside sync");

endmodule

/* File: include/csc_pkg.sv */
// Package for the cam signal conditioning block: register map, field
// layouts, reset values and the encodings shared by design and bench.
// Assumes a byte address bus with one 32-bit word per register.
package csc_pkg;

    // Register byte offsets
    localparam logic [7:0] CSC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] CSC_DELAY_OFS   = 8'h04;
    localparam logic [7:0] CSC_STRETCH_OFS = 8'h08;
    localparam logic [7:0] CSC_STALL_OFS   = 8'h0c;
    localparam logic [7:0] CSC_RUN_OFS     = 8'h10;
    localparam logic [7:0] CSC_STATUS_OFS  = 8'h14;
    localparam logic [7:0] CSC_ZTDC_OFS    = 8'h18;
    localparam logic [7:0] CSC_INJMAP_OFS  = 8'h1c;
    localparam logic [7:0] CSC_PFIMAP_OFS  = 8'h20;
    localparam logic [7:0] CSC_CYL_OFS     = 8'h40;

    // Control word field positions and cylinder slot count
    localparam int CSC_CTRL_W       = 6;
    localparam int CSC_CLR_BIT      = 8;
    localparam int CSC_CYL_N        = 8;

    // Reset values
    localparam logic [5:0]  CSC_CTRL_RST  = 6'h00;
    localparam logic [7:0]  CSC_TEETH_RST = 8'h00;
    localparam logic [15:0] CSC_STALL_RST = 16'h0064;
    localparam logic [15:0] CSC_RUN_RST   = 16'h0258;
    localparam logic [15:0] CSC_ANGLE_RST = 16'h0000;

    // Control register, bit 5 downward
    typedef struct packed {
        logic encoder_pat;      // bit 5: encoder pattern selected
        logic auto_clear;       // bit 4: auto_fault_clear_on_start
        logic index_gate_mode;  // bit 3: 1 gated, 0 bypassed
        logic phase_input_sel;  // bit 2: 0 input a, 1 input b
        logic cam_stretch_en;   // bit 1
        logic cam_delay_en;     // bit 0
    } csc_ctl_t;

    typedef enum logic [1:0] {
        CSC_STALLED  = 2'h0,
        CSC_CRANKING = 2'h1,
        CSC_RUNNING  = 2'h2
    } csc_run_t;

    typedef enum logic [1:0] {
        CSC_H_NORMAL = 2'h0,
        CSC_H_ERROR  = 2'h1,
        CSC_H_HIGH   = 2'h2,
        CSC_H_LOW    = 2'h3
    } csc_health_t;

    typedef enum logic [1:0] {
        CSC_D_IDLE  = 2'b00,
        CSC_D_COUNT = 2'b01,
        CSC_D_PULSE = 2'b11
    } csc_dly_t;

endpackage

/* File: verif/csc_wheel.sv */
// Crank wheel stand-in: a square crank tooth train with a tooth timer.
// Assumes the bench clock; a tooth lasts two halves of HALF clocks.
`timescale 1ns/1ps

module csc_wheel #(
    parameter int HALF = 16
) (
    input  wire logic clock_i,
    input  wire logic run_i,
    output logic      crank_o,
    output int        tick_o
);
    // Tooth timer; a stopped wheel stands still low, as a real one would
    always @(posedge clock_i) begin
        if (!run_i) begin
            tick_o  <= 0;
            crank_o <= 1'b0;
        end else begin
            tick_o  <= (tick_o == 2 * HALF - 1) ? 0 : tick_o + 1;
            crank_o <= (tick_o == 2 * HALF - 1) || (tick_o < HALF - 1);
        end
    end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the cam signal conditioning block.
// Assumes csc_top, its package and the csc_wheel crank stand-in.
`timescale 1ns/1ps

module tb;
    import csc_pkg::*;

    typedef struct {
        logic [5:0]  ctl;
        logic [7:0]  dly;
        logic [7:0]  str;
        logic        on_b;
        int          w;
        logic [15:0] exp;
    } csc_row_t;

    localparam int HALF = 16;

    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        cam_a = 1'b0;
    logic        cam_b = 1'b0;
    logic        index = 1'b0;
    logic [15:0] speed = 16'h0000;
    logic        feature = 1'b0;
    logic        synced = 1'b0;
    logic [3:0]  fault_set = 4'h0;
    logic        run = 1'b0;
    logic        crank;
    logic        phase_out_o;
    logic        index_o;
    logic        sync_block_o;
    logic        health_valid_o;
    logic [31:0] rdata_o;
    logic [3:0]  fault_flags_o;
    logic [1:0]  engine_run_state_o;
    logic [1:0]  cam_phase_health_o;
    int          tick;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [15:0] seen;
    logic [15:0] spd [5] = '{16'h0032, 16'h0064, 16'h0065, 16'h0257,
                             16'h0259};
    logic [1:0]  st [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};

    // Cam path cases: cam rises early in tooth 0; one seen bit per half
    // tooth, even bits are the crank high halves
    csc_row_t rows [10] = '{
        '{6'h00, 8'h00, 8'h00, 1'b0, 3, 16'h0007},
        '{6'h04, 8'h00, 8'h00, 1'b0, 3, 16'h0000},
        '{6'h04, 8'h00, 8'h00, 1'b1, 3, 16'h0007},
        '{6'h01, 8'h00, 8'h00, 1'b0, 3, 16'h0002},
        '{6'h01, 8'h03, 8'h00, 1'b0, 3, 16'h0080},
        '{6'h02, 8'h00, 8'h03, 1'b0, 1, 16'h003f},
        '{6'h02, 8'h00, 8'h01, 1'b0, 5, 16'h0003},
        '{6'h03, 8'h02, 8'h02, 1'b0, 3, 16'h00e0},
        '{6'h02, 8'h00, 8'h00, 1'b0, 3, 16'h0000},
        '{6'h07, 8'h01, 8'h02, 1'b1, 3, 16'h0038}
    };

    csc_wheel #(.HALF(HALF)) wheel (.clock_i(clock_i), .run_i(run),
                                    .crank_o(crank), .tick_o(tick));

    csc_top dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .crank_i(crank), .phase_input_a_i(cam_a), .phase_input_b_i(cam_b),
        .encoder_index_pulse_i(index), .engine_speed_i(speed),
        .feature_i(feature), .synced_i(synced), .fault_set_i(fault_set),
        .phase_out_o(phase_out_o), .index_o(index_o),
        .fault_flags_o(fault_flags_o), .sync_block_o(sync_block_o),
        .engine_run_state_o(engine_run_state_o),
        .cam_phase_health_o(cam_phase_health_o),
        .health_valid_o(health_valid_o));

    // 40 MHz clock
    always #12.5 clock_i = ~clock_i;

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("test timeout");
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] sv,
                       input logic [31:0] ev);
        n_checks++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, ev, sv);
        end
    endtask

    // Bus write: one strobe cycle; the edge after it leaves a gap
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    // Bus read: data taken in the single cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] ev);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        @(posedge clock_i);
        chk("rdata_o", rdata_o, ev);
    endtask

    // Cam pulse of w halves from tooth 0; samples well after crank edges
    task automatic cam_run(input logic on_b, input int w);
        seen = 16'h0000;
        do @(posedge clock_i); while (tick != 0);
        cam_a <= !on_b;
        cam_b <= on_b;
        for (int k = 0; k < 16; k++) begin
            do @(posedge clock_i); while (tick != (k % 2) * HALF + 12);
            seen[k] = phase_out_o;
            if (k == w - 1) begin
                cam_a <= 1'b0;
                cam_b <= 1'b0;
            end
        end
    endtask

    task automatic idx_case(input logic [5:0] ctl, input logic a, b, ev);
        wr(CSC_CTRL_OFS, 32'(ctl));
        @(posedge clock_i);
        cam_a <= a;
        cam_b <= b;
        index <= 1'b1;
        repeat (10) @(posedge clock_i);
        chk("index_o", 32'(index_o), 32'(ev));
        index <= 1'b0;
        cam_a <= 1'b0;
        cam_b <= 1'b0;
        repeat (10) @(posedge clock_i);
    endtask

    // Four features, cam level set well before each one
    task automatic feed(input logic [3:0] pat, input logic [1:0] h,
                        input logic v);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            cam_a <= pat[i];
            repeat (8) @(posedge clock_i);
            feature <= 1'b1;
            @(posedge clock_i);
            feature <= 1'b0;
        end
        repeat (3) @(posedge clock_i);
        chk("cam_phase_health_o", 32'(cam_phase_health_o), 32'(h));
        chk("health_valid_o", 32'(health_valid_o), 32'(v));
    endtask

    task automatic fault(input logic [3:0] f);
        @(posedge clock_i);
        fault_set <= f;
        @(posedge clock_i);
        fault_set <= 4'h0;
        @(posedge clock_i);
        chk("fault_flags_o", 32'(fault_flags_o), 32'(f));
        chk("sync_block_o", 32'(sync_block_o), 32'h1);
    endtask

    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("phase_out_o", 32'(phase_out_o), 32'h0);
        chk("engine_run_state_o", 32'(engine_run_state_o), 32'h0);
        rdchk(CSC_STALL_OFS, 32'h0000_0064);
        rdchk(CSC_RUN_OFS, 32'h0000_0258);
        wr(CSC_ZTDC_OFS, 32'hffff_ffd3);
        rdchk(CSC_ZTDC_OFS, 32'h0000_ffd3);
        wr(CSC_CYL_OFS + 8'h1c, 32'h0000_01e0);
        rdchk(CSC_CYL_OFS + 8'h1c, 32'h0000_01e0);
        rdchk(CSC_CYL_OFS, 32'h0);
        wr(CSC_INJMAP_OFS, 32'hffff_ffff);
        rdchk(CSC_INJMAP_OFS, 32'h00ff_ffff);
        wr(CSC_PFIMAP_OFS, 32'hffff_ffff);
        rdchk(CSC_PFIMAP_OFS, 32'h0000_0fff);
        wr(8'h05, 32'h0000_0011);
        rdchk(CSC_DELAY_OFS, 32'h0);
        rdchk(8'h3c, 32'h0);
        $display("test registers done");
        run <= 1'b1;
        foreach (rows[r]) begin
            wr(CSC_CTRL_OFS, 32'(rows[r].ctl));
            wr(CSC_DELAY_OFS, 32'(rows[r].dly));
            wr(CSC_STRETCH_OFS, 32'(rows[r].str));
            cam_run(rows[r].on_b, rows[r].w);
            chk("phase_out_o", 32'(seen), 32'(rows[r].exp));
            $display("test cam row %0d done", r);
        end
        run <= 1'b0;
        idx_case(6'h28, 1'b0, 1'b0, 1'b0);
        idx_case(6'h28, 1'b1, 1'b0, 1'b1);
        idx_case(6'h2c, 1'b1, 1'b0, 1'b0);
        idx_case(6'h2c, 1'b0, 1'b1, 1'b1);
        idx_case(6'h20, 1'b0, 1'b0, 1'b1);
        $display("test index done");
        foreach (spd[i]) begin
            @(posedge clock_i);
            speed <= spd[i];
            repeat (3) @(posedge clock_i);
            chk("engine_run_state_o", 32'(engine_run_state_o),
                32'(st[i]));
        end
        wr(CSC_STALL_OFS, 32'h0000_0200);
        speed <= 16'h012c;
        repeat (3) @(posedge clock_i);
        chk("engine_run_state_o", 32'(engine_run_state_o), 32'h0);
        $display("test engine state done");
        fault(4'h5);
        wr(CSC_CTRL_OFS, 32'h0000_0010);
        repeat (20) @(posedge clock_i);
        chk("fault_flags_o", 32'(fault_flags_o), 32'h5);
        wr(CSC_STALL_OFS, 32'h0000_0064);
        repeat (5) @(posedge clock_i);
        chk("fault_flags_o", 32'(fault_flags_o), 32'h0);
        chk("sync_block_o", 32'(sync_block_o), 32'h0);
        wr(CSC_CTRL_OFS, 32'h0);
        fault(4'ha);
        wr(CSC_CTRL_OFS, 32'h0000_0100);
        repeat (2) @(posedge clock_i);
        chk("fault_flags_o", 32'(fault_flags_o), 32'h0);
        rdchk(CSC_CTRL_OFS, 32'h0);
        $display("test faults done");
        synced <= 1'b1;
        feed(4'b0101, CSC_H_NORMAL, 1'b1);
        feed(4'b1111, CSC_H_HIGH, 1'b1);
        feed(4'b0000, CSC_H_LOW, 1'b1);
        feed(4'b1011, CSC_H_ERROR, 1'b1);
        chk("sync_block_o", 32'(sync_block_o), 32'h0);
        wr(CSC_CTRL_OFS, 32'h0000_0020);
        feed(4'b0101, CSC_H_NORMAL, 1'b0);
        wr(CSC_CTRL_OFS, 32'h0);
        synced <= 1'b0;
        feed(4'b0101, CSC_H_NORMAL, 1'b0);
        $display("test health done");
        // Live levels: index and input b high, engine still cranking
        cam_b <= 1'b1;
        index <= 1'b1;
        repeat (4) @(posedge clock_i);
        rdchk(CSC_STATUS_OFS, 32'h0000_1810);
        $display("test status done");
        // Mid-run reset must drop sticky flags and settings
        fault(4'h3);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("fault_flags_o", 32'(fault_flags_o), 32'h0);
        chk("sync_block_o", 32'(sync_block_o), 32'h0);
        rdchk(CSC_DELAY_OFS, 32'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule
